// File: design/oms_defines.vh
// constants for the outgoing mailbox scanner
// assumes a byte-wide host command port and a 32-bit word memory master
//
// Summary of operation
// (R1) setup reply byte 0 names bus letter
// (R2) setup reply byte 1 gives BIOS code
// (R3) setup reply bytes 2-3 give segment limit
// (R4) opcode 8F plus one byte sets mode
// (R5) strict mode checks only pointer mailbox
// (R6) strict mode keeps per-target order of host
// (R7) aggressive mode hunts through whole outgoing array
// (R8) 24-bit mode masks addresses to 16 MB
// (R9) host lays out N outgoing then N incoming
// (R10) host initializes mailboxes before any work
// (R11) host should fill outgoing slots round-robin
// (R12) action code in byte 0, cleared after copy
// (R13) incoming written only when its byte 0 zero
// (R14) empty mailbox stops scan until start command
// (R15) opcode 81 takes count then address LSB first
// (R16) pointer starts at first slot and wraps
`ifndef OMS_DEFINES_VH
`define OMS_DEFINES_VH
// ****************************************************************
// host command opcodes
// ****************************************************************
`define OMS_OP_INIT24    8'h01
`define OMS_OP_START     8'h02
`define OMS_OP_INIT32    8'h81
`define OMS_OP_INQX      8'h8D
`define OMS_OP_RRMODE    8'h8F
`define OMS_NPRM_INIT24  3'h4
`define OMS_NPRM_INIT32  3'h5
`define OMS_NPRM_ONE     3'h1
// ****************************************************************
// mailbox fields and modes
// ****************************************************************
`define OMS_MODE_STRICT  8'h00
`define OMS_MODE_AGGR    8'h01
`define OMS_ACT_FREE     8'h00
`define OMS_ADDR24_MASK  32'h00FFFFFF
`define OMS_BE_BYTE0     4'h1
`define OMS_BE_ALL       4'hF
// ****************************************************************
// setup reply defaults
// ****************************************************************
`define OMS_BUS_PCI      8'h45
`define OMS_BUS_AT       8'h41
`define OMS_BUS_ALT      8'h4D
`define OMS_BIOS_OFF     8'h00
`define OMS_SG_MAX_DFLT  16'h0080
`define OMS_RIDX_BUS     8'h00
`define OMS_RIDX_BIOS    8'h01
`define OMS_RIDX_SG_LO   8'h02
`define OMS_RIDX_SG_HI   8'h03
`endif

// File: design/oms_scanner.v
// outgoing mailbox scanner with command parser and completion writer
// assumes a word memory master with one-cycle ack, little-endian lanes
`timescale 1ns/10ps
`include "oms_defines.vh"
module oms_scanner #(
   parameter [7:0]  BUS_TYPE  = `OMS_BUS_PCI,
   parameter [7:0]  BIOS_CODE = `OMS_BIOS_OFF,
   parameter [15:0] SG_MAX    = `OMS_SG_MAX_DFLT
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        cmd_valid_i,
   input  wire [7:0]  cmd_byte_i,
   output reg         cmd_busy_o,
   output reg         reply_valid_o,
   output reg  [7:0]  reply_byte_o,
   input  wire        reply_ready_i,
   output reg         mem_req_o,
   output reg         mem_we_o,
   output reg  [31:0] mem_addr_o,
   output reg  [3:0]  mem_be_o,
   output reg  [31:0] mem_wdata_o,
   input  wire [31:0] mem_rdata_i,
   input  wire        mem_ack_i,
   output reg         out_valid_o,
   output reg  [7:0]  out_action_o,
   output reg  [23:0] out_ccb_o,
   input  wire        cmp_valid_i,
   input  wire [7:0]  cmp_code_i,
   input  wire [23:0] cmp_ccb_i,
   output reg         cmp_ready_o,
   output reg         init_done_o,
   output reg         scanning_o
);
   // ****************************************************************
   // states and helpers
   // ****************************************************************
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ORD  = 3'h1;
   localparam [2:0] ST_OCLR = 3'h2;
   localparam [2:0] ST_IRD  = 3'h3;
   localparam [2:0] ST_IWR  = 3'h4;

   // mailbox word address, cut to 16 MB in 24-bit mode
   function [31:0] mb_addr;
      input [31:0] base;
      input [8:0]  idx;
      input        m24;
      reg   [31:0] s;
      begin
         s = base + {21'h000000, idx, 2'h0};
         mb_addr = m24 ? (s & `OMS_ADDR24_MASK) : s; // R8
      end
   endfunction

   // next slot, back to the first after the last
   function [7:0] wrap;
      input [7:0] p;
      input [7:0] c;
      begin
         wrap = ((p + 8'h01) == c) ? 8'h00 : (p + 8'h01); // R16
      end
   endfunction

   reg [2:0]  st_q;
   reg [7:0]  op_q;
   reg [2:0]  pleft_q;
   reg [2:0]  pidx_q;
   reg [7:0]  cnt_new_q;
   reg [31:0] base_new_q;
   reg [7:0]  cnt_q;
   reg [31:0] base_q;
   reg        m24_q;
   reg        aggr_q;
   reg [7:0]  optr_q;
   reg [7:0]  iptr_q;
   reg [7:0]  chk_q;
   reg [7:0]  rcnt_q;
   reg [7:0]  ridx_q;
   wire [7:0] ridx_nxt;
   wire [7:0] rbyte;
   wire       cmd_take;

   assign cmd_take = cmd_valid_i & ~cmd_busy_o;
   assign ridx_nxt = reply_valid_o ? (ridx_q + 8'h01) : 8'h00;

   oms_setup_reply u_reply (
      .idx_i       (ridx_nxt),
      .bus_type_i  (BUS_TYPE),
      .bios_code_i (BIOS_CODE),
      .sg_max_i    (SG_MAX),
      .byte_o      (rbyte)
   );

   // ****************************************************************
   // mailbox walker
   // ****************************************************************
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_q         <= ST_IDLE;
         mem_req_o    <= 1'b0;
         mem_we_o     <= 1'b0;
         mem_addr_o   <= 32'h00000000;
         mem_be_o     <= 4'h0;
         mem_wdata_o  <= 32'h00000000;
         out_valid_o  <= 1'b0;
         out_action_o <= 8'h00;
         out_ccb_o    <= 24'h000000;
         cmp_ready_o  <= 1'b0;
         optr_q       <= 8'h00;
         iptr_q       <= 8'h00;
         chk_q        <= 8'h00;
         scanning_o   <= 1'b0;
      end else begin
         out_valid_o <= 1'b0;
         cmp_ready_o <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               // completions go first so the adapter never starves them
               if (init_done_o && cmp_valid_i && !cmp_ready_o) begin
                  mem_req_o  <= 1'b1;
                  mem_we_o   <= 1'b0;
                  mem_be_o   <= `OMS_BE_ALL;
                  mem_addr_o <= mb_addr(base_q,
                                        {1'b0, cnt_q} + {1'b0, iptr_q},
                                        m24_q); // R9
                  st_q       <= ST_IRD;
               end else if (scanning_o) begin
                  mem_req_o  <= 1'b1;
                  mem_we_o   <= 1'b0;
                  mem_be_o   <= `OMS_BE_ALL;
                  mem_addr_o <= mb_addr(base_q, {1'b0, optr_q}, m24_q);
                  st_q       <= ST_ORD;
               end
            end
            ST_ORD: if (mem_ack_i) begin
               if (mem_rdata_i[7:0] != `OMS_ACT_FREE) begin
                  out_valid_o  <= 1'b1;
                  out_action_o <= mem_rdata_i[7:0];        // R12
                  out_ccb_o    <= {mem_rdata_i[15:8], mem_rdata_i[23:16],
                                   mem_rdata_i[31:24]};    // R12
                  mem_we_o     <= 1'b1;
                  mem_be_o     <= `OMS_BE_BYTE0;
                  mem_wdata_o  <= 32'h00000000;            // R12
                  optr_q       <= wrap(optr_q, cnt_q);     // R5 R6
                  chk_q        <= 8'h00;
                  st_q         <= ST_OCLR;
               end else begin
                  mem_req_o <= 1'b0;
                  st_q      <= ST_IDLE;
                  if (!aggr_q) begin
                     scanning_o <= 1'b0;                   // R5 R14
                  end else begin
                     optr_q <= wrap(optr_q, cnt_q);        // R7
                     chk_q  <= chk_q + 8'h01;
                     if ((chk_q + 8'h01) == cnt_q) begin
                        scanning_o <= 1'b0;                // R7 R14
                        chk_q      <= 8'h00;
                     end
                  end
               end
            end
            ST_OCLR: if (mem_ack_i) begin
               mem_req_o <= 1'b0;
               st_q      <= ST_IDLE;
            end
            ST_IRD: if (mem_ack_i) begin
               if (mem_rdata_i[7:0] == `OMS_ACT_FREE) begin // R13
                  mem_we_o    <= 1'b1;
                  mem_be_o    <= `OMS_BE_ALL;
                  mem_wdata_o <= {cmp_ccb_i[7:0], cmp_ccb_i[15:8],
                                  cmp_ccb_i[23:16], cmp_code_i}; // R13
                  st_q        <= ST_IWR;
               end else begin
                  // slot still owned by the host: retry on a later pass
                  mem_req_o <= 1'b0;
                  st_q      <= ST_IDLE;
               end
            end
            ST_IWR: if (mem_ack_i) begin
               mem_req_o   <= 1'b0;
               cmp_ready_o <= 1'b1;
               iptr_q      <= wrap(iptr_q, cnt_q);
               st_q        <= ST_IDLE;
            end
            default: begin
               mem_req_o <= 1'b0;
               st_q      <= ST_IDLE;
            end
         endcase
         // command effects last so a start wins over a stop
         if (cmd_take && pleft_q == 3'h0 && cmd_byte_i == `OMS_OP_START
             && init_done_o) begin
            scanning_o <= 1'b1;                            // R14
            chk_q      <= 8'h00;
         end
         if (cmd_take && pleft_q == 3'h1 && cnt_new_q != 8'h00 &&
             (op_q == `OMS_OP_INIT24 || op_q == `OMS_OP_INIT32)) begin
            optr_q     <= 8'h00;                           // R16 R10
            iptr_q     <= 8'h00;
            chk_q      <= 8'h00;
            scanning_o <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // command parser and setup reply
   // ****************************************************************
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         op_q          <= 8'h00;
         pleft_q       <= 3'h0;
         pidx_q        <= 3'h0;
         cnt_new_q     <= 8'h00;
         base_new_q    <= 32'h00000000;
         cnt_q         <= 8'h00;
         base_q        <= 32'h00000000;
         m24_q         <= 1'b1;
         aggr_q        <= 1'b0;
         init_done_o   <= 1'b0;
         cmd_busy_o    <= 1'b0;
         reply_valid_o <= 1'b0;
         reply_byte_o  <= 8'h00;
         rcnt_q        <= 8'h00;
         ridx_q        <= 8'h00;
      end else begin
         if (reply_valid_o && reply_ready_i) begin
            ridx_q <= ridx_nxt;
            reply_byte_o <= rbyte;
            if (ridx_nxt == rcnt_q) begin
               reply_valid_o <= 1'b0;
               cmd_busy_o    <= 1'b0;
            end
         end
         if (cmd_take) begin
            if (pleft_q == 3'h0) begin
               op_q   <= cmd_byte_i;
               pidx_q <= 3'h0;
               case (cmd_byte_i)
                  `OMS_OP_INIT24: pleft_q <= `OMS_NPRM_INIT24;
                  `OMS_OP_INIT32: pleft_q <= `OMS_NPRM_INIT32; // R15
                  `OMS_OP_INQX:   pleft_q <= `OMS_NPRM_ONE;
                  `OMS_OP_RRMODE: pleft_q <= `OMS_NPRM_ONE;    // R4
                  default:        pleft_q <= 3'h0;
               endcase
            end else begin
               pleft_q <= pleft_q - 3'h1;
               pidx_q  <= pidx_q + 3'h1;
               if (op_q == `OMS_OP_RRMODE) begin
                  aggr_q <= (cmd_byte_i == `OMS_MODE_AGGR);    // R4 R7
               end
               if (op_q == `OMS_OP_INQX) begin
                  rcnt_q <= cmd_byte_i;
                  ridx_q <= 8'h00;
                  if (cmd_byte_i != 8'h00) begin
                     reply_valid_o <= 1'b1;
                     reply_byte_o  <= rbyte;                   // R1
                     cmd_busy_o    <= 1'b1;
                  end
               end
               if (op_q == `OMS_OP_INIT32) begin
                  case (pidx_q)
                     3'h0:    cnt_new_q <= cmd_byte_i;             // R15
                     3'h1:    base_new_q[7:0]   <= cmd_byte_i;     // R15
                     3'h2:    base_new_q[15:8]  <= cmd_byte_i;
                     3'h3:    base_new_q[23:16] <= cmd_byte_i;
                     default: base_new_q[31:24] <= cmd_byte_i;
                  endcase
               end
               if (op_q == `OMS_OP_INIT24) begin
                  case (pidx_q)
                     3'h0:    cnt_new_q <= cmd_byte_i;
                     3'h1:    base_new_q <= {8'h00, cmd_byte_i, 16'h0000};
                     3'h2:    base_new_q[15:8] <= cmd_byte_i;
                     default: base_new_q[7:0]  <= cmd_byte_i;
                  endcase
               end
               // a zero count is refused and leaves the old array
               if (pleft_q == 3'h1 && cnt_new_q != 8'h00) begin
                  if (op_q == `OMS_OP_INIT32) begin
                     cnt_q       <= cnt_new_q;
                     base_q      <= {cmd_byte_i, base_new_q[23:0]};
                     m24_q       <= 1'b0;                      // R8
                     init_done_o <= 1'b1;                      // R10
                  end
                  if (op_q == `OMS_OP_INIT24) begin
                     cnt_q       <= cnt_new_q;
                     base_q      <= {8'h00, base_new_q[23:8], cmd_byte_i};
                     m24_q       <= 1'b1;                      // R8
                     init_done_o <= 1'b1;                      // R10
                  end
               end
            end
         end
      end
   end
endmodule // oms_scanner

// File: design/oms_setup_reply.v
// setup reply byte selector
// assumes the caller registers the selected byte
`timescale 1ns/10ps
`include "oms_defines.vh"
module oms_setup_reply (
   input  wire [7:0]  idx_i,
   input  wire [7:0]  bus_type_i,
   input  wire [7:0]  bios_code_i,
   input  wire [15:0] sg_max_i,
   output reg  [7:0]  byte_o
);
   always @* begin
      case (idx_i)
         `OMS_RIDX_BUS:   byte_o = bus_type_i;     // R1
         `OMS_RIDX_BIOS:  byte_o = bios_code_i;    // R2
         `OMS_RIDX_SG_LO: byte_o = sg_max_i[7:0];  // R3
         `OMS_RIDX_SG_HI: byte_o = sg_max_i[15:8]; // R3
         // bytes past the documented four read as zero
         default:         byte_o = 8'h00;
      endcase
   end
endmodule // oms_setup_reply

// File: tb/oms_mem_model.sv
// host memory holding the mailbox array, word wide
// assumes one request at a time, acked after 0 to 3 wait cycles
`timescale 1ns/10ps
module oms_mem_model (
   input  wire        clk_i,
   input  wire        req_i,
   input  wire        we_i,
   input  wire [31:0] addr_i,
   input  wire [3:0]  be_i,
   input  wire [31:0] wdata_i,
   output reg  [31:0] rdata_o,
   output reg         ack_o
);
   reg     [31:0] mem [0:255];
   reg     [1:0]  wait_q;
   integer        i;
   // ******************************
   // memory and answer
   // ******************************
   initial begin
      for (i = 0; i < 256; i = i + 1) mem[i] = 32'h00000000;
      ack_o = 1'b0;
      rdata_o = 32'h00000000;
      wait_q = 2'h0;
   end
   always @(posedge clk_i) begin
      if (req_i && !ack_o && wait_q == 2'h0) begin
         ack_o <= 1'b1;
         rdata_o <= mem[addr_i[9:2]];
         for (i = 0; i < 4; i = i + 1)
            if (we_i && be_i[i])
               mem[addr_i[9:2]][8*i+:8] <= wdata_i[8*i+:8];
      end else begin
         ack_o <= 1'b0;
         // released data bus toggles, never holds the last word
         rdata_o <= ~rdata_o;
         if (req_i && !ack_o) wait_q <= wait_q - 2'h1;
         else wait_q <= $urandom_range(3, 0);
      end
   end
endmodule // oms_mem_model

// File: tb/oms_scanner_properties.sv
// port checker for the mailbox scanner
// assumes a bind onto every oms_scanner instance
`timescale 1ns/10ps
module oms_scanner_properties (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire        cmd_busy_o,
   input wire        reply_valid_o,
   input wire [7:0]  reply_byte_o,
   input wire        reply_ready_i,
   input wire        mem_req_o,
   input wire        mem_we_o,
   input wire [31:0] mem_addr_o,
   input wire [3:0]  mem_be_o,
   input wire [31:0] mem_wdata_o,
   input wire        mem_ack_i,
   input wire        out_valid_o,
   input wire [7:0]  out_action_o,
   input wire        cmp_valid_i,
   input wire [7:0]  cmp_code_i,
   input wire [23:0] cmp_ccb_i,
   input wire        cmp_ready_o,
   input wire        init_done_o,
   input wire        scanning_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // ******************************
   // memory steps
   // ******************************
   sequence s_clear;
      mem_req_o && mem_we_o && mem_be_o == 4'h1 && mem_wdata_o[7:0] == 8'h00;
   endsequence
   sequence s_fill;
      mem_req_o && mem_we_o && mem_be_o == 4'hF;
   endsequence
   sequence s_read;
      mem_req_o && !mem_we_o;
   endsequence
   // ******************************
   // properties
   // ******************************
   a_req_held: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
      $stable(mem_addr_o) && $stable(mem_wdata_o) && $stable(mem_be_o))
      else $error("request changed before ack");
   a_copy_clears: assert property (out_valid_o |-> s_clear)
      else $error("copy without byte 0 clear");
   a_copy_active: assert property (out_valid_o |->
      out_action_o != 8'h00)
      else $error("free mailbox copied");
   a_fill_data: assert property (s_fill |->
      mem_wdata_o == {cmp_ccb_i[7:0], cmp_ccb_i[15:8], cmp_ccb_i[23:16],
      cmp_code_i})
      else $error("incoming word wrong");
   a_ready_after: assert property (cmp_ready_o |->
      $past(mem_ack_i && mem_we_o && mem_be_o == 4'hF))
      else $error("completion ready without write");
   a_reply_stands: assert property (reply_valid_o && !reply_ready_i |=>
      reply_valid_o && $stable(reply_byte_o))
      else $error("reply byte dropped");
   a_reply_busy: assert property (reply_valid_o |-> cmd_busy_o)
      else $error("reply without busy");
   a_no_init: assert property (!init_done_o |->
      !scanning_o && !mem_req_o)
      else $error("activity before init");
   a_word_addr: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
      else $error("unaligned mailbox address");
   a_scan_reads: assert property ($rose(scanning_o) && !cmp_valid_i |->
      ##[1:3] s_read)
      else $error("scan without read");
endmodule // oms_scanner_properties

bind oms_scanner oms_scanner_properties chk_u (.clk_i, .rst_n_i, .cmd_busy_o,
   .reply_valid_o, .reply_byte_o, .reply_ready_i, .mem_req_o, .mem_we_o,
   .mem_addr_o, .mem_be_o, .mem_wdata_o, .mem_ack_i, .out_valid_o,
   .out_action_o, .cmp_valid_i, .cmp_code_i, .cmp_ccb_i, .cmp_ready_o,
   .init_done_o, .scanning_o);

// File: tb/oms_scanner_tb_top.sv
// self-checking bench for the mailbox scanner
// assumes oms_mem_model as host memory and the bound port checker
`timescale 1ns/10ps
`include "oms_defines.vh"
module oms_scanner_tb_top;
   reg         clk_i = 1'b0;
   reg         rst_n_i = 1'b0;
   reg         cmd_valid_i = 1'b0;
   reg  [7:0]  cmd_byte_i = 8'h00;
   reg         reply_ready_i = 1'b0;
   reg         cmp_valid_i = 1'b0;
   reg  [7:0]  cmp_code_i = 8'h00;
   reg  [23:0] cmp_ccb_i = 24'h000000;
   wire        cmd_busy_o, reply_valid_o, mem_req_o, mem_we_o, mem_ack_i;
   wire [7:0]  reply_byte_o, out_action_o;
   wire [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
   wire [3:0]  mem_be_o;
   wire        out_valid_o, cmp_ready_o, init_done_o, scanning_o;
   wire [23:0] out_ccb_o;
   integer     bad_count = 0, n_compared = 0, cmp_n = 0, j, k;
   reg  [31:0] outq [$];
   reg  [31:0] rnd;
   reg  [23:0] ccb [0:3];
   reg         hi_seen = 1'b0;
   always #2.5 clk_i = ~clk_i;
   oms_scanner #(.BUS_TYPE(8'h41), .BIOS_CODE(8'hD4), .SG_MAX(16'h0102)) dut_u (
      .clk_i, .rst_n_i, .cmd_valid_i, .cmd_byte_i, .cmd_busy_o, .reply_valid_o,
      .reply_byte_o, .reply_ready_i, .mem_req_o, .mem_we_o, .mem_addr_o,
      .mem_be_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .out_valid_o,
      .out_action_o, .out_ccb_o, .cmp_valid_i, .cmp_code_i, .cmp_ccb_i,
      .cmp_ready_o, .init_done_o, .scanning_o);
   oms_mem_model mem_u (.clk_i(clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .be_i(mem_be_o), .wdata_i(mem_wdata_o),
      .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
   // ******************************
   // monitors and tasks
   // ******************************
   always @(posedge clk_i) begin
      if (out_valid_o) outq.push_back({out_action_o, out_ccb_o});
      if (cmp_ready_o) cmp_n = cmp_n + 1;
      if (mem_req_o && mem_addr_o[31:24] != 8'h00) hi_seen = 1'b1;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task send(input [7:0] b);
      begin
         cmd_valid_i <= 1'b1;
         cmd_byte_i <= b;
         @(posedge clk_i);
         cmd_valid_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   // bytes go out from the top of the vector
   task send_n(input [47:0] v, input integer n);
      for (j = 0; j < n; j = j + 1) send(v[47-8*j -: 8]);
   endtask
   // mailbox word as laid out in host memory, address MSB in byte 1
   function [31:0] mb_word(input [7:0] code, input [23:0] c);
      mb_word = {c[7:0], c[15:8], c[23:16], code};
   endfunction
   task put(input [7:0] idx, input [7:0] act, input [23:0] c);
      mem_u.mem[idx] = mb_word(act, c);
   endtask
   task reply(input [7:0] e);
      begin
         @(negedge clk_i);
         for (k = 0; k < 50 && reply_valid_o !== 1'b1; k = k + 1)
            @(negedge clk_i);
         chk(reply_byte_o, e);
         @(posedge clk_i);
         reply_ready_i <= 1'b1;
         @(posedge clk_i);
         reply_ready_i <= 1'b0;
      end
   endtask
   // the quiet tail catches extra copies
   task wait_outs(input integer n);
      begin
         for (k = 0; k < 400 && outq.size() < n; k = k + 1) @(negedge clk_i);
         repeat (40) @(negedge clk_i);
         chk(outq.size(), n);
         @(posedge clk_i);
      end
   endtask
   task test_done;
      begin
         if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // ******************************
   // tests
   // ******************************
   initial begin
      #200000;
      bad_count = bad_count + 1;
      test_done;
   end
   initial begin
      void'($urandom(32'h88C27033));
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      send_n(48'h8D0500000000, 2);
      reply(8'h41);
      reply(8'hD4);
      reply(8'h02);
      reply(8'h01);
      reply(8'h00);
      send_n(48'h810400013412, 6);
      for (j = 0; j < 4; j = j + 1) begin
         rnd = $urandom;
         ccb[j] = rnd[23:0];
      end
      put(8'h40, 8'h01, ccb[0]);
      put(8'h41, 8'h02, ccb[1]);
      put(8'h43, 8'h01, ccb[3]);
      send(`OMS_OP_START);
      wait_outs(2);
      chk(outq.pop_front(), {8'h01, ccb[0]});
      chk(outq.pop_front(), {8'h02, ccb[1]});
      chk(mem_u.mem[8'h40][7:0], 8'h00);
      chk(mem_u.mem[8'h43][7:0], 8'h01);
      send_n(48'h8F0100000000, 2);
      send(`OMS_OP_START);
      wait_outs(1);
      chk(outq.pop_front(), {8'h01, ccb[3]});
      send_n(48'h8F0000000000, 2);
      put(8'h40, 8'h01, ccb[2]);
      send(`OMS_OP_START);
      wait_outs(1);
      chk(outq.pop_front(), {8'h01, ccb[2]});
      chk(hi_seen, 1'b1);
      mem_u.mem[8'h44] = 32'h00000001;
      for (j = 1; j < 5; j = j + 1) begin
         rnd = $urandom;
         cmp_valid_i <= 1'b1;
         cmp_code_i <= j[7:0];
         cmp_ccb_i <= rnd[23:0];
         if (j == 1) begin
            repeat (40) @(negedge clk_i);
            chk(cmp_n, 0);
            mem_u.mem[8'h44] = 32'h00000000;
         end
         // ready is looked at while it stands, valid drops at the next edge
         for (k = 0; k < 300 && cmp_ready_o !== 1'b1; k = k + 1)
            @(negedge clk_i);
         @(posedge clk_i);
         cmp_valid_i <= 1'b0;
         chk(mem_u.mem[8'h43 + j], mb_word(j[7:0], rnd[23:0]));
         // one idle edge so valid is never lowered and raised in one step
         @(posedge clk_i);
      end
      send_n(48'h0104FFFFF800, 5);
      hi_seen = 1'b0;
      for (j = 0; j < 4; j = j + 1) begin
         rnd = $urandom;
         ccb[j] = rnd[23:0];
         put(8'hFE + j[7:0], 8'h01, ccb[j]);
      end
      send(`OMS_OP_START);
      wait_outs(4);
      for (j = 0; j < 4; j = j + 1)
         chk(outq.pop_front(), {8'h01, ccb[j]});
      chk(hi_seen, 1'b0);
      test_done;
   end
endmodule // oms_scanner_tb_top
